// ==== core/spl_fifo.sv ====
// spl_fifo: synchronous valid/ready buffer with parameter width and depth
// assumes one clock; pop and push on the same cycle are allowed
`timescale 1ns/10ps
module spl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spl_fifo

// ==== core/spl_lowpower.sv ====
// spl_lowpower: serial slave with wait/halt behaviour and shared interrupt
// assumes an external master drives link clock and select; system clock
// is gated by the wider chip in halt, modelled here by halt_in
`timescale 1ns/10ps
module spl_lowpower #(
  parameter int unsigned FIFO_DEPTH = spl_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic                      link_clk_in,
  input  wire logic                      link_sel_n_in,
  input  wire logic                      link_mosi_in,
  output logic                           link_miso_out,
  output logic                           link_miso_oe_out,
  input  wire logic                      slave_mode_in,
  input  wire logic                      ext_select_in,
  input  wire logic                      internal_select_bit,
  input  wire logic                      serial_irq_enable,
  input  wire logic                      cpu_irq_mask_in,
  input  wire logic                      wait_mode_in,
  input  wire logic                      halt_in,
  input  wire logic                      mode_fault_in,
  input  wire logic [spl_pkg::DATA_W-1:0] tx_data_in,
  input  wire logic                      flag_clear_in,
  input  wire logic                      data_read_in,
  output logic [spl_pkg::DATA_W-1:0]     serial_data_reg,
  output logic                           data_valid_out,
  output logic                           transfer_done_flag,
  output logic                           overrun_flag,
  output logic                           mode_fault_flag,
  output logic                           irq_out,
  output logic                           wake_out,
  output logic                           halt_state_out,
  output logic                           link_ready_out
);
  localparam int unsigned DW = spl_pkg::DATA_W;

  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // link side reuses the synced reset: a release synced to the link clock
  // would eat the first two bits, as that clock only runs inside frames

  // link side shifter; it runs on the master's clock, so it keeps
  // working while the system clock is stopped in halt
  logic [DW-1:0]                 shift_rx;
  logic [DW-1:0]                 shift_tx;
  logic [spl_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [DW-1:0]                 link_word;
  logic                          link_tgl;
  wire  [DW-1:0]                 next_rx = {shift_rx[DW-2:0], link_mosi_in};
  wire                           frame_on = !link_sel_n_in && slave_mode_in;
  wire                           last_bit = (bit_cnt == spl_pkg::BIT_LAST);

  always_ff @(posedge link_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_rx  <= spl_pkg::DATA_RESET;
      bit_cnt   <= '0;
      link_word <= spl_pkg::DATA_RESET;
      link_tgl  <= 1'b0;
    end else if (frame_on) begin
      shift_rx <= next_rx;
      bit_cnt  <= bit_cnt + 1'b1;
      if (last_bit) begin
        link_word <= next_rx;
        link_tgl  <= !link_tgl;
      end
    end
  end

  // first bit must stand before the first rising edge, so it comes
  // straight from the byte; the rest shift out on falling edges
  always_ff @(negedge link_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_tx <= spl_pkg::DATA_RESET;
    end else if (frame_on) begin
      shift_tx <= (bit_cnt == 3'h1) ? {tx_data_in[DW-2:0], 1'b0} : {shift_tx[DW-2:0], 1'b0};
    end
  end
  assign link_miso_out    = (bit_cnt == '0) ? tx_data_in[DW-1] : shift_tx[DW-1];
  assign link_miso_oe_out = frame_on;

  // select level caught in system domain
  logic sel_s1;
  logic sel_s2;
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      tg_s1  <= 1'b0;
      tg_s2  <= 1'b0;
      tg_s3  <= 1'b0;
    end else begin
      sel_s1 <= link_sel_n_in;
      sel_s2 <= sel_s1;
      tg_s1  <= link_tgl;
      tg_s2  <= tg_s1;
      tg_s3  <= tg_s2;
    end
  end
  // word is stable long before the toggle is seen two flops later
  wire word_evt = tg_s2 ^ tg_s3;

  // effective select: external pin or internal bit
  wire sel_low = ext_select_in ? !sel_s2 : !internal_select_bit;

  // power state tracking
  spl_pkg::spl_pwr_t pwr;
  spl_pkg::spl_pwr_t next_pwr;
  logic              wake_armed;
  wire               halt_entry = halt_in && (pwr == spl_pkg::SPL_RUN);
  // freeze from the very edge that sees halt, not one cycle later
  wire               frozen     = halt_in || (pwr == spl_pkg::SPL_HALTED);

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      spl_pkg::SPL_RUN: begin
        if (halt_in) begin
          next_pwr = spl_pkg::SPL_HALTED;
        end
      end
      spl_pkg::SPL_HALTED: begin
        if (!halt_in) begin
          next_pwr = slave_mode_in ? spl_pkg::SPL_WOKEN : spl_pkg::SPL_RUN;
        end
      end
      spl_pkg::SPL_WOKEN: begin
        if (!slave_mode_in || word_evt) begin
          next_pwr = spl_pkg::SPL_RUN;
        end
      end
      default: begin
        next_pwr = spl_pkg::SPL_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr        <= spl_pkg::SPL_RUN;
      wake_armed <= 1'b0;
    end else begin
      pwr <= next_pwr;
      if (halt_entry) begin
        wake_armed <= sel_low && slave_mode_in;
      end
    end
  end
  assign halt_state_out = (pwr != spl_pkg::SPL_RUN);

  // received words queue up while frozen, so up to FIFO_DEPTH of them are kept until wake
  logic          fifo_valid;
  logic [DW-1:0] fifo_data;
  logic          fifo_pop;
  spl_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n),
    .in_data_in    (link_word),
    .in_valid_in   (word_evt),
    .in_ready_out  (link_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop)
  );

  // every queued word completes a transfer; an overrun word is dropped
  // so the unread byte stays for the service routine
  logic data_full;
  wire  take_word = fifo_valid && !frozen;
  wire  ovr_evt   = take_word && transfer_done_flag && !flag_clear_in;
  wire  load_word = take_word && !ovr_evt;
  assign fifo_pop = take_word;

  // a word that lands while halted with wake_armed set is a pending completion
  logic halt_done;
  wire  done_evt = take_word;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_reg    <= spl_pkg::DATA_RESET;
      data_full          <= 1'b0;
      transfer_done_flag <= 1'b0;
      overrun_flag       <= 1'b0;
      mode_fault_flag    <= 1'b0;
      halt_done          <= 1'b0;
    end else if (frozen) begin
      // registers hold; only note that a word arrived for wake-up
      halt_done <= halt_done || (word_evt && wake_armed);
    end else begin
      halt_done <= 1'b0;
      if (load_word) begin
        serial_data_reg <= fifo_data;
      end
      data_full <= load_word || (data_full && !data_read_in);
      // set wins over a clear in the same cycle
      transfer_done_flag <= done_evt || (transfer_done_flag && !flag_clear_in);
      overrun_flag <= ovr_evt || (overrun_flag && !flag_clear_in);
      mode_fault_flag <= mode_fault_in || (mode_fault_flag && !flag_clear_in);
    end
  end
  assign data_valid_out = data_full;

  // one shared request line; wait mode alters nothing here
  wire any_evt = transfer_done_flag || overrun_flag || mode_fault_flag;
  assign irq_out = any_evt && serial_irq_enable && cpu_irq_mask_in;

  // halt exit only from a completed slave word; in wait mode any flag, a fault too, wakes via irq_out
  assign wake_out = wait_mode_in ? irq_out
                  : (halt_done && serial_irq_enable && cpu_irq_mask_in);
endmodule : spl_lowpower

// ==== core/spl_pkg.sv ====
// spl_pkg: shared constants for the low-power serial slave block
// assumes an 8-bit frame, mode 0 style sampling on the link clock
package spl_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_CNT_W    = 3;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [2:0]  BIT_LAST     = 3'h7;

  typedef enum logic [1:0] {
    SPL_RUN      = 2'b00,
    SPL_HALTED   = 2'b01,
    SPL_WOKEN    = 2'b10
  } spl_pwr_t;
endpackage : spl_pkg

// ==== verification/spl_lowpower_assertions.sv ====
// spl_chk: port-level timing checks for the low-power serial block
// assumes binding onto spl_lowpower; every input mirrors a port of it
`timescale 1ns/10ps
module spl_chk (
  input wire logic                       clk_in,
  input wire logic                       nrst_in,
  input wire logic                       halt_in,
  input wire logic                       wait_mode_in,
  input wire logic                       slave_mode_in,
  input wire logic                       serial_irq_enable,
  input wire logic                       cpu_irq_mask_in,
  input wire logic                       mode_fault_in,
  input wire logic [spl_pkg::DATA_W-1:0] serial_data_reg,
  input wire logic                       data_valid_out,
  input wire logic                       transfer_done_flag,
  input wire logic                       overrun_flag,
  input wire logic                       mode_fault_flag,
  input wire logic                       irq_out,
  input wire logic                       wake_out,
  input wire logic                       halt_state_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_IRQ_SHARE:
    assert property (irq_out == (serial_irq_enable && cpu_irq_mask_in &&
      (transfer_done_flag || overrun_flag || mode_fault_flag))) else $error("irq mismatch");
  AST_WAIT_WAKE:
    assert property (wait_mode_in |-> wake_out == irq_out) else $error("wait wake");
  AST_HALT_FREEZE:
    assert property ($past(halt_in) |-> $stable({serial_data_reg, transfer_done_flag,
      overrun_flag, mode_fault_flag})) else $error("halt not frozen");
  AST_OVR_CAUSE:
    assert property ($rose(overrun_flag) |-> $past(transfer_done_flag)) else $error("ovr");
  AST_DONE_DATA:
    assert property ($rose(transfer_done_flag) |-> data_valid_out) else $error("no data");
  AST_MODE_FAULT_FLAG_SET:
    assert property (mode_fault_in && !halt_in && !$past(halt_in) |=> mode_fault_flag)
      else $error("mode_fault_flag");
  AST_LEAVE_SLAVE:
    assert property (halt_state_out && !slave_mode_in && !halt_in |-> ##[0:2] !halt_state_out)
      else $error("halt state stuck");
  AST_HALT_NO_EN:
    assert property (halt_in && !wait_mode_in && !(serial_irq_enable && cpu_irq_mask_in)
      |-> !wake_out) else $error("wake while disabled");
endmodule : spl_chk
bind spl_lowpower spl_chk u_spl_chk (.*);

// ==== verification/spl_master.sv ====
// spl_master: behavioural external serial master, msb first, 64 ns bit clock
// assumes the bench calls send_byte; clock stands still between frames
`timescale 1ns/10ps
module spl_master (
  output logic      link_clk_out,
  output logic      link_sel_n_out,
  output logic      link_mosi_out,
  input  wire logic link_miso_in
);
  logic [7:0] rx_byte;
  initial begin
    link_clk_out = 1'b0;
    link_sel_n_out = 1'b1;
    link_mosi_out = 1'b0;
  end
  // keep_sel holds select low over halt entry or for the extra wake cycle
  task automatic send_byte(input logic [7:0] b, input logic keep_sel);
    #5 link_sel_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_mosi_out = b[i];
      #32 link_clk_out = 1'b1;
      rx_byte = {rx_byte[6:0], link_miso_in};
      #32 link_clk_out = 1'b0;
    end
    // idle data line flips so a stale bit never reads as valid
    link_mosi_out = ~b[0];
    #32 if (!keep_sel) link_sel_n_out = 1'b1;
  endtask : send_byte
endmodule : spl_master

// ==== verification/tb_spl_lowpower.sv ====
// tb_spl_lowpower: directed checks of wait, halt, wake and shared irq
// assumes spl_master as far side and the bound port checker
`timescale 1ns/10ps
module tb_spl_lowpower;
  logic       clk_in, nrst_in, link_clk_in, link_sel_n_in, link_mosi_in, slave_mode_in;
  logic       ext_select_in, internal_select_bit, serial_irq_enable, cpu_irq_mask_in;
  logic       wait_mode_in, halt_in, mode_fault_in, flag_clear_in, data_read_in;
  logic [7:0] tx_data_in, serial_data_reg;
  logic       link_miso_out, link_miso_oe_out, data_valid_out, transfer_done_flag;
  logic       overrun_flag, mode_fault_flag, irq_out, wake_out, halt_state_out, link_ready_out;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles = 0;
  spl_lowpower u_spl_lowpower (.*);
  spl_master u_spl_master (
    .link_clk_out   (link_clk_in),
    .link_sel_n_out (link_sel_n_in),
    .link_mosi_out  (link_mosi_in),
    .link_miso_in   (link_miso_out)
  );
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // a hang costs far less than this; every frame is about 70 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic await(ref logic s);
    for (int n = 0; n < 2000 && s !== 1'b1; n++) @(posedge clk_in);
    #1;
  endtask : await
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic pulse_clr;
    @(posedge clk_in) flag_clear_in <= 1'b1;
    @(posedge clk_in) flag_clear_in <= 1'b0;
    step(2);
  endtask : pulse_clr
  initial begin
    {nrst_in, wait_mode_in, halt_in, mode_fault_in, flag_clear_in, data_read_in} = '0;
    {slave_mode_in, ext_select_in, internal_select_bit} = 3'h7;
    {serial_irq_enable, cpu_irq_mask_in} = 2'h3;
    tx_data_in = 8'h5A;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    step(3);
    u_spl_master.send_byte(8'hA5, 1'b0);
    check("miso", 8'h5A, u_spl_master.rx_byte);
    await(transfer_done_flag);
    check("data", 8'hA5, serial_data_reg);
    check("data_valid", 8'h01, data_valid_out);
    check("link_ready", 8'h01, link_ready_out);
    check("irq", 8'h01, irq_out);
    u_spl_master.send_byte(8'h33, 1'b0);
    await(overrun_flag);
    check("overrun", 8'h01, overrun_flag);
    check("ovr_keeps", 8'hA5, serial_data_reg);
    pulse_clr();
    check("irq_clear", 8'h00, irq_out);
    @(posedge clk_in) {cpu_irq_mask_in, mode_fault_in} <= 2'h1;
    @(posedge clk_in) mode_fault_in <= 1'b0;
    step(2);
    check("fault", 8'h01, mode_fault_flag);
    check("irq_masked", 8'h00, irq_out);
    @(posedge clk_in) {cpu_irq_mask_in, serial_irq_enable} <= 2'h2;
    step(1);
    check("irq_disabled", 8'h00, irq_out);
    @(posedge clk_in) serial_irq_enable <= 1'b1;
    step(1);
    check("irq_fault", 8'h01, irq_out);
    pulse_clr();
    @(posedge clk_in) wait_mode_in <= 1'b1;
    u_spl_master.send_byte(8'h96, 1'b0);
    await(transfer_done_flag);
    check("wait_data", 8'h96, serial_data_reg);
    check("wait_wake", 8'h01, wake_out);
    @(posedge clk_in) wait_mode_in <= 1'b0;
    pulse_clr();
    u_spl_master.send_byte(8'h11, 1'b1);
    check("miso_oe", 8'h01, link_miso_oe_out);
    await(transfer_done_flag);
    pulse_clr();
    @(posedge clk_in) halt_in <= 1'b1;
    u_spl_master.send_byte(8'h3C, 1'b1);
    await(wake_out);
    check("halt_wake", 8'h01, wake_out);
    check("halt_flag", 8'h00, transfer_done_flag);
    u_spl_master.send_byte(8'hC3, 1'b0);
    check("halt_frozen", 8'h11, serial_data_reg);
    @(posedge clk_in) halt_in <= 1'b0;
    await(transfer_done_flag);
    check("halt_data", 8'h3C, serial_data_reg);
    await(overrun_flag);
    check("halt_overrun", 8'h01, overrun_flag);
    check("halt_keep", 8'h3C, serial_data_reg);
    @(posedge clk_in) slave_mode_in <= 1'b0;
    step(3);
    check("leave_slave", 8'h00, halt_state_out);
    pulse_clr();
    @(posedge clk_in) {slave_mode_in, ext_select_in, halt_in} <= 3'h5;
    u_spl_master.send_byte(8'h77, 1'b0);
    step(20);
    check("no_wake", 8'h00, wake_out);
    @(posedge clk_in) {ext_select_in, halt_in} <= 2'h2;
    await(transfer_done_flag);
    check("late_data", 8'h77, serial_data_reg);
    check("halt_state", 8'h01, halt_state_out);
    pulse_clr();
    u_spl_master.send_byte(8'h5A, 1'b0);
    await(transfer_done_flag);
    step(2);
    check("resume", 8'h5A, serial_data_reg);
    check("normal_state", 8'h00, halt_state_out);
    give_verdict();
  end
endmodule : tb_spl_lowpower
